// ---- include/egf_consts.vh ----
// Constants for the electronic gearing follower.
// Included by the follower, the checker and the bench; definitions only.
`ifndef EGF_CONSTS_VH
`define EGF_CONSTS_VH
`define EGF_ADDR_NUM 4'h0
`define EGF_ADDR_DEN 4'h1
`define EGF_ADDR_CTRL 4'h2
`define EGF_ADDR_DIST 4'h3
`define EGF_ADDR_TVEL 4'h4
`define EGF_ADDR_OSCN 4'h5
`define EGF_ADDR_OSCD 4'h6
`define EGF_ADDR_STAT 4'h7
`define EGF_ADDR_MPOS 4'h8
`define EGF_ADDR_SPOS 4'h9
`define EGF_ADDR_CMD 4'hA
`define EGF_CTRL_INV 0
`define EGF_CTRL_QSRC 1
`define EGF_CMD_RATIO 0
`define EGF_CMD_DIST 1
`define EGF_CMD_TIME 2
`define EGF_CMD_STOP 3
`define EGF_ST_IDLE 2'h0
`define EGF_ST_RATIO 2'h1
`define EGF_ST_DIST 2'h2
`define EGF_ST_TIME 2'h3
`define EGF_DEN_RST 32'h00000001
`define EGF_NUM_RST 32'h00000001
`define EGF_ZERO32 32'h00000000
`define EGF_DIV_LAST 6'h1F
`endif

// ---- hw/egf_quad_dec.v ----
// Quadrature decoder: turns an A/B pair into count pulses.
// Assumes A and B are already synchronous to the clock.
`timescale 1ns/1ps
module egf_quad_dec (
   input wire core_clk_in,
   input wire rst_b_in,
   input wire a_in,
   input wire b_in,
   input wire invert_in,
   output reg step_out,
   output reg fwd_out
);
   reg a_reg;
   reg b_reg;
   wire moved;
   wire a_leads;
   assign moved = (a_in ^ a_reg) | (b_in ^ b_reg);
   // A leads B when the new A equals the old B inverted
   assign a_leads = a_in ^ b_reg;
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         a_reg <= 1'b0;
         b_reg <= 1'b0;
         step_out <= 1'b0;
         fwd_out <= 1'b0;
      end else begin
         a_reg <= a_in;
         b_reg <= b_in;
         // Double changes are illegal steps and are dropped
         step_out <= moved & ~((a_in ^ a_reg) & (b_in ^ b_reg));
         fwd_out <= a_leads ^ invert_in;
      end
   end
endmodule // egf_quad_dec

// ---- hw/egf_gear_follower.v ----
// Electronic gearing follower: master quadrature in, slave steps out,
// quadrature retransmit out. Assumes synchronous pins and a plain
// register port with read data one cycle after the read strobe.
// Function
// - Slave speed is numerator over denominator
// - A leading B counts master forward
// - Distance mode advances on forward master only
// - Invert bit swaps master forward sense
// - Ratio mode runs until stop command
// - Distance mode stops after programmed distance
// - Time mode moves without master input
// - Accept master quadrature and drive quadrature out
// - Quadrature output source selectable
// - Motor feedback output scaled by ratio, counting up for either motor direction
`timescale 1ns/1ps
`include "egf_consts.vh"
module egf_gear_follower (
   input wire core_clk_in,
   input wire rst_b_in,
   input wire [3:0] addr_in,
   input wire [31:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [31:0] rdata_out,
   input wire mst_a_in,
   input wire mst_b_in,
   input wire mot_a_in,
   input wire mot_b_in,
   output reg slv_step_out,
   output reg slv_dir_out,
   output reg qout_a_out,
   output reg qout_b_out,
   output reg busy_out
);
   reg [31:0] num_reg;
   reg [31:0] den_reg;
   reg [1:0] ctrl_reg;
   reg [31:0] dist_reg;
   reg [31:0] tvel_reg;
   reg [31:0] oscn_reg;
   reg [31:0] oscd_reg;
   reg [1:0] state_reg;
   reg [31:0] mpos_reg;
   reg [31:0] spos_reg;
   reg [31:0] left_reg;
   reg [32:0] acc_reg;
   reg [31:0] pend_reg;
   reg [31:0] tacc_reg;
   reg [32:0] oacc_reg;
   reg [31:0] opend_reg;
   reg [1:0] ophase_reg;
   reg [5:0] div_cnt_reg;
   reg [32:0] div_rem_reg;
   reg div_busy_reg;
   reg [31:0] quo_reg;
   reg tbusy_reg;
   wire m_step;
   wire m_fwd;
   wire mo_step;
   wire mo_fwd;
   wire cmd_wr;
   wire [32:0] acc_sum;
   wire take_master;
   wire [32:0] tsum;
   wire [32:0] osum;
   wire [31:0] ostep_num;
   wire stop_cmd;
   wire [32:0] div_shift;
   wire [32:0] div_diff;
   wire div_fits;

   // One restoring step per clock; the remainder always stays below den
   assign div_shift = {div_rem_reg[31:0], acc_reg[32]};
   assign div_fits = (div_shift >= {1'b0, den_reg});
   assign div_diff = div_shift - {1'b0, den_reg};
   egf_quad_dec u_mst (
      .core_clk_in(core_clk_in),
      .rst_b_in(rst_b_in),
      .a_in(mst_a_in),
      .b_in(mst_b_in),
      .invert_in(ctrl_reg[`EGF_CTRL_INV]),
      .step_out(m_step),
      .fwd_out(m_fwd)
   );

   egf_quad_dec u_mot (
      .core_clk_in(core_clk_in),
      .rst_b_in(rst_b_in),
      .a_in(mot_a_in),
      .b_in(mot_b_in),
      .invert_in(1'b0),
      .step_out(mo_step),
      .fwd_out(mo_fwd)
   );

   assign cmd_wr = wr_in && (addr_in == `EGF_ADDR_CMD);
   assign stop_cmd = cmd_wr && wdata_in[`EGF_CMD_STOP];
   // Ratio mode follows both directions; distance mode only forward
   assign take_master = m_step && !div_busy_reg &&
      ((state_reg == `EGF_ST_RATIO) ||
       ((state_reg == `EGF_ST_DIST) && m_fwd));
   // Each master count taken adds the numerator; division spreads it out
   assign acc_sum = acc_reg + {1'b0, num_reg};
   assign tsum = {1'b0, tacc_reg} + {1'b0, tvel_reg};
   assign ostep_num = oscn_reg;
   assign osum = oacc_reg + {1'b0, ostep_num};

   // Register writes
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         num_reg <= `EGF_NUM_RST;
         den_reg <= `EGF_DEN_RST;
         ctrl_reg <= 2'h0;
         dist_reg <= `EGF_ZERO32;
         tvel_reg <= `EGF_ZERO32;
         oscn_reg <= `EGF_NUM_RST;
         oscd_reg <= `EGF_DEN_RST;
      end else if (wr_in) begin
         case (addr_in)
            `EGF_ADDR_NUM: num_reg <= wdata_in;
            // A zero denominator would never divide; clamp to one
            `EGF_ADDR_DEN: den_reg <= (wdata_in == `EGF_ZERO32) ? `EGF_DEN_RST : wdata_in;
            `EGF_ADDR_CTRL: ctrl_reg <= wdata_in[1:0];
            `EGF_ADDR_DIST: dist_reg <= wdata_in;
            `EGF_ADDR_TVEL: tvel_reg <= wdata_in;
            `EGF_ADDR_OSCN: oscn_reg <= wdata_in;
            `EGF_ADDR_OSCD: oscd_reg <= (wdata_in == `EGF_ZERO32) ? `EGF_DEN_RST : wdata_in;
            default: ;
         endcase
      end
   end

   // Mode state machine, master position and slave accumulation
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_reg <= `EGF_ST_IDLE;
         mpos_reg <= `EGF_ZERO32;
         left_reg <= `EGF_ZERO32;
         acc_reg <= 33'h000000000;
         pend_reg <= `EGF_ZERO32;
         div_busy_reg <= 1'b0;
         div_cnt_reg <= 6'h00;
         div_rem_reg <= 33'h000000000;
         quo_reg <= `EGF_ZERO32;
         tacc_reg <= `EGF_ZERO32;
         tbusy_reg <= 1'b0;
      end else begin
         if (m_step) begin
            mpos_reg <= m_fwd ? mpos_reg + 32'h00000001 : mpos_reg - 32'h00000001;
         end
         if (take_master) begin
            // Restoring division of the accumulated product by den
            acc_reg <= acc_sum;
            div_rem_reg <= 33'h000000000;
            quo_reg <= `EGF_ZERO32;
            div_cnt_reg <= 6'h00;
            div_busy_reg <= 1'b1;
         end else if (div_busy_reg) begin
            if (div_fits) begin
               div_rem_reg <= div_diff;
               quo_reg <= {quo_reg[30:0], 1'b1};
            end else begin
               div_rem_reg <= div_shift;
               quo_reg <= {quo_reg[30:0], 1'b0};
            end
            acc_reg <= {acc_reg[31:0], 1'b0};
            div_cnt_reg <= div_cnt_reg + 6'h01;
            if (div_cnt_reg == `EGF_DIV_LAST + 6'h01) begin
               div_busy_reg <= 1'b0;
               // Remainder is kept for the next master count
               acc_reg <= {1'b0, (div_fits ? div_diff[31:0] : div_shift[31:0])};
               // Quotient above 32 bits cannot occur for one count; top bit dropped
               pend_reg <= pend_reg + {quo_reg[30:0], div_fits};
            end
         end else if (pend_reg != `EGF_ZERO32 && slv_step_out == 1'b0) begin
            pend_reg <= pend_reg - 32'h00000001;
            if (state_reg == `EGF_ST_DIST) begin
               left_reg <= left_reg - 32'h00000001;
               if (left_reg == 32'h00000001) begin
                  state_reg <= `EGF_ST_IDLE;
                  pend_reg <= `EGF_ZERO32;
               end
            end
         end
         // Time mode: fractional velocity accumulator, no master needed
         tbusy_reg <= 1'b0;
         if (state_reg == `EGF_ST_TIME) begin
            tacc_reg <= tsum[31:0];
            if (tsum[32]) begin
               tbusy_reg <= 1'b1;
               left_reg <= left_reg - 32'h00000001;
               if (left_reg == 32'h00000001) begin
                  state_reg <= `EGF_ST_IDLE;
               end
            end
         end
         if (stop_cmd) begin
            state_reg <= `EGF_ST_IDLE;
            pend_reg <= `EGF_ZERO32;
         end else if (cmd_wr && state_reg == `EGF_ST_IDLE) begin
            acc_reg <= 33'h000000000;
            tacc_reg <= `EGF_ZERO32;
            left_reg <= dist_reg;
            if (wdata_in[`EGF_CMD_RATIO]) begin
               state_reg <= `EGF_ST_RATIO;
            end else if (wdata_in[`EGF_CMD_DIST] && dist_reg != `EGF_ZERO32) begin
               state_reg <= `EGF_ST_DIST;
            end else if (wdata_in[`EGF_CMD_TIME] && dist_reg != `EGF_ZERO32) begin
               state_reg <= `EGF_ST_TIME;
            end
         end
      end
   end

   // Slave step output; direction follows master in ratio mode
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         slv_step_out <= 1'b0;
         slv_dir_out <= 1'b1;
         spos_reg <= `EGF_ZERO32;
         busy_out <= 1'b0;
      end else begin
         slv_step_out <= 1'b0;
         busy_out <= (state_reg != `EGF_ST_IDLE);
         if (take_master) begin
            slv_dir_out <= (state_reg == `EGF_ST_RATIO) ? m_fwd : 1'b1;
         end
         if ((!take_master && !div_busy_reg && pend_reg != `EGF_ZERO32 &&
              !slv_step_out && !stop_cmd) || tbusy_reg) begin
            slv_step_out <= 1'b1;
            spos_reg <= (slv_dir_out || tbusy_reg) ? spos_reg + 32'h00000001 :
               spos_reg - 32'h00000001;
         end
      end
   end

   // Quadrature retransmit; scaled motor feedback or raw master
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         oacc_reg <= 33'h000000000;
         opend_reg <= `EGF_ZERO32;
         ophase_reg <= 2'h0;
         qout_a_out <= 1'b0;
         qout_b_out <= 1'b0;
      end else begin
         if (ctrl_reg[`EGF_CTRL_QSRC]) begin
            qout_a_out <= mst_a_in;
            qout_b_out <= mst_b_in;
         end else begin
            // Motor output scaled by oscn/oscd, one count per clock at most
            if (mo_step) begin
               if (osum >= {1'b0, oscd_reg}) begin
                  oacc_reg <= osum - {1'b0, oscd_reg};
                  opend_reg <= opend_reg + 32'h00000001;
               end else begin
                  oacc_reg <= osum;
               end
               if (!mo_fwd) begin
                  ophase_reg <= ophase_reg;
               end
            end else if (opend_reg != `EGF_ZERO32) begin
               opend_reg <= opend_reg - 32'h00000001;
               ophase_reg <= ophase_reg + {1'b0, mo_fwd | 1'b1};
            end
            qout_a_out <= ophase_reg[1];
            qout_b_out <= ophase_reg[1] ^ ophase_reg[0];
         end
      end
   end

   // Register read port
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdata_out <= `EGF_ZERO32;
      end else if (rd_in) begin
         case (addr_in)
            `EGF_ADDR_NUM: rdata_out <= num_reg;
            `EGF_ADDR_DEN: rdata_out <= den_reg;
            `EGF_ADDR_CTRL: rdata_out <= {30'h00000000, ctrl_reg};
            `EGF_ADDR_DIST: rdata_out <= dist_reg;
            `EGF_ADDR_TVEL: rdata_out <= tvel_reg;
            `EGF_ADDR_OSCN: rdata_out <= oscn_reg;
            `EGF_ADDR_OSCD: rdata_out <= oscd_reg;
            `EGF_ADDR_STAT: rdata_out <= {30'h00000000, state_reg};
            `EGF_ADDR_MPOS: rdata_out <= mpos_reg;
            `EGF_ADDR_SPOS: rdata_out <= spos_reg;
            default: rdata_out <= `EGF_ZERO32;
         endcase
      end else begin
         rdata_out <= `EGF_ZERO32;
      end
   end
endmodule // egf_gear_follower

// ---- test/egf_gear_chk.sv ----
// Port checker for the gearing follower.
// Bound to every follower instance; sees its ports only.
`timescale 1ns/1ps
`include "egf_consts.vh"
module egf_gear_chk (
   input wire core_clk_in,
   input wire rst_b_in,
   input wire [3:0] addr_in,
   input wire [31:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   input wire [31:0] rdata_out,
   input wire mst_a_in,
   input wire mst_b_in,
   input wire slv_step_out,
   input wire qout_a_out,
   input wire qout_b_out,
   input wire busy_out
);
   reg pass_reg;
   wire cmd_wr = wr_in && addr_in == `EGF_ADDR_CMD;
   // Control register is internal, so its source bit is mirrored here
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) pass_reg <= 1'b0;
      else if (wr_in && addr_in == `EGF_ADDR_CTRL) pass_reg <= wdata_in[`EGF_CTRL_QSRC];
   end
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);
   a_step_gap: assert property (slv_step_out |=> !slv_step_out)
      else $error("slave steps back to back");
   a_pass_copy: assert property (pass_reg && $past(pass_reg) |->
      qout_a_out == $past(mst_a_in) && qout_b_out == $past(mst_b_in))
      else $error("passthrough output differs from master pins");
   // A source switch may jump the phase, so only a settled source is checked
   a_qout_gray: assert property ($stable(pass_reg) && pass_reg == $past(pass_reg, 2) |->
      !($changed(qout_a_out) && $changed(qout_b_out)))
      else $error("quadrature output moved both phases");
   a_stop_halts: assert property (cmd_wr && wdata_in[`EGF_CMD_STOP] |-> ##[1:4] !busy_out)
      else $error("stop did not end motion");
   a_ratio_start: assert property (cmd_wr && wdata_in[`EGF_CMD_RATIO] && !wdata_in[`EGF_CMD_STOP]
      && !busy_out && !$past(cmd_wr) |-> ##[1:3] busy_out)
      else $error("ratio mode did not start");
   a_idle_quiet: assert property (!busy_out [*3] |-> !slv_step_out)
      else $error("slave step while idle");
   a_stat_range: assert property (rd_in && addr_in == `EGF_ADDR_STAT |=>
      rdata_out[31:2] == 30'h00000000)
      else $error("state read out of range");
   a_den_read: assert property (rd_in && addr_in == `EGF_ADDR_DEN |=>
      rdata_out != 32'h00000000)
      else $error("denominator reads zero");
endmodule // egf_gear_chk
bind egf_gear_follower egf_gear_chk u_chk (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .mst_a_in(mst_a_in), .mst_b_in(mst_b_in),
   .slv_step_out(slv_step_out), .qout_a_out(qout_a_out), .qout_b_out(qout_b_out),
   .busy_out(busy_out));

// ---- test/egf_qenc_model.sv ----
// Quadrature source standing for a master encoder or motor feedback.
// Assumes step_in is a one-cycle request set just after a rising edge.
`timescale 1ns/1ps
module egf_qenc_model (
   input wire core_clk_in,
   input wire step_in,
   input wire fwd_in,
   output wire a_out,
   output wire b_out
);
   reg [1:0] ph_reg = 2'h0;
   // Phase 1 raises A before B, so counting up means A leads B
   assign a_out = ph_reg == 2'h1 || ph_reg == 2'h2;
   assign b_out = ph_reg[1];
   always @(posedge core_clk_in) begin
      if (step_in) ph_reg <= fwd_in ? ph_reg + 2'h1 : ph_reg - 2'h1;
   end
endmodule // egf_qenc_model

// ---- test/tb_top.sv ----
// Self-checking bench for the gearing follower.
// Assumes the design's register port and synchronous quadrature pins.
`timescale 1ns/1ps
`include "egf_consts.vh"
module tb_top;
   reg clk = 1'b0;
   reg rst_b = 1'b0;
   reg [3:0] addr = 4'h0;
   reg [31:0] wdata = 32'h00000000;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg ms = 1'b0;
   reg mf = 1'b1;
   reg ts = 1'b0;
   reg [1:0] qprev = 2'h0;
   wire [31:0] rdata;
   wire ma, mb, ta, tb, step, dir, qa, qb, busy;
   integer miscompares = 0;
   integer compares = 0;
   integer steps = 0;
   integer qedges = 0;
   integer base;
   always #10 clk = ~clk;
   egf_gear_follower u_dut (.core_clk_in(clk), .rst_b_in(rst_b), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .mst_a_in(ma),
      .mst_b_in(mb), .mot_a_in(ta), .mot_b_in(tb), .slv_step_out(step),
      .slv_dir_out(dir), .qout_a_out(qa), .qout_b_out(qb), .busy_out(busy));
   egf_qenc_model u_mst (.core_clk_in(clk), .step_in(ms), .fwd_in(mf), .a_out(ma), .b_out(mb));
   egf_qenc_model u_mot (.core_clk_in(clk), .step_in(ts), .fwd_in(1'b1), .a_out(ta), .b_out(tb));
   always @(posedge clk) begin
      if (step) steps <= steps + 1;
      if ({qa, qb} !== qprev) qedges <= qedges + 1;
      qprev <= {qa, qb};
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wreg(input [3:0] a, input [31:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   task rreg(input [3:0] a, input [31:0] exp);
      begin
         @(posedge clk);
         addr <= a;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         #1 chk(rdata, exp);
      end
   endtask
   // Master counts are spaced past the division time so none is refused
   task mv(input fwd, input integer n, input mot);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1) begin
            @(posedge clk);
            mf <= fwd;
            if (mot) ts <= 1'b1;
            else ms <= 1'b1;
            @(posedge clk);
            ms <= 1'b0;
            ts <= 1'b0;
            repeat (40) @(posedge clk);
         end
      end
   endtask
   task conclude;
      begin
         $display("compares %0d miscompares %0d", compares, miscompares);
         if (miscompares == 0 && compares > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   initial begin
      #400000;
      miscompares = miscompares + 1;
      conclude;
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      rreg(`EGF_ADDR_NUM, 32'h00000001);
      rreg(`EGF_ADDR_OSCD, 32'h00000001);
      wreg(`EGF_ADDR_DEN, 32'h00000000);
      rreg(`EGF_ADDR_DEN, 32'h00000001);
      rreg(4'hF, 32'h00000000);
      $display("test registers done");
      mv(1'b1, 4, 1'b0);
      rreg(`EGF_ADDR_MPOS, 32'h00000004);
      wreg(`EGF_ADDR_CTRL, 32'h00000001);
      mv(1'b1, 2, 1'b0);
      rreg(`EGF_ADDR_MPOS, 32'h00000002);
      wreg(`EGF_ADDR_CTRL, 32'h00000000);
      $display("test direction done");
      wreg(`EGF_ADDR_NUM, 32'h00000003);
      wreg(`EGF_ADDR_DEN, 32'h00000002);
      base = steps;
      wreg(`EGF_ADDR_CMD, 32'h00000001);
      mv(1'b1, 6, 1'b0);
      chk(steps - base, 9);
      rreg(`EGF_ADDR_STAT, 32'h00000001);
      wreg(`EGF_ADDR_CMD, 32'h00000008);
      repeat (4) @(posedge clk);
      rreg(`EGF_ADDR_STAT, 32'h00000000);
      $display("test ratio done");
      wreg(`EGF_ADDR_NUM, 32'h00000001);
      wreg(`EGF_ADDR_DEN, 32'h00000001);
      wreg(`EGF_ADDR_DIST, 32'h00000003);
      base = steps;
      wreg(`EGF_ADDR_CMD, 32'h00000002);
      mv(1'b0, 2, 1'b0);
      chk(steps - base, 0);
      mv(1'b1, 5, 1'b0);
      chk(steps - base, 3);
      rreg(`EGF_ADDR_STAT, 32'h00000000);
      $display("test distance done");
      wreg(`EGF_ADDR_DIST, 32'h00000004);
      wreg(`EGF_ADDR_TVEL, 32'h80000000);
      base = steps;
      wreg(`EGF_ADDR_CMD, 32'h00000004);
      repeat (40) @(posedge clk);
      chk(steps - base, 4);
      chk({31'h00000000, dir}, 32'h00000001);
      $display("test time done");
      wreg(`EGF_ADDR_CTRL, 32'h00000002);
      mv(1'b1, 1, 1'b0);
      chk({30'h00000000, qa, qb}, {30'h00000000, ma, mb});
      wreg(`EGF_ADDR_CTRL, 32'h00000000);
      wreg(`EGF_ADDR_OSCD, 32'h00000002);
      repeat (4) @(posedge clk);
      base = qedges;
      mv(1'b1, 4, 1'b1);
      chk(qedges - base, 2);
      $display("test output done");
      conclude;
   end
endmodule // tb_top
